// ### rtl/dtc_pkg.sv
// constants and types for the dual timer with capture/reload
package dtc_pkg;
	localparam int unsigned TMR_W = 16;
	localparam logic [15:0] TMR_RST = 16'h0000;
	localparam logic [15:0] TMR_MAX = 16'hffff;
	localparam int unsigned STEP_CYCLES = 2;
	localparam int unsigned PRE_W = 3;
	localparam logic [PRE_W-1:0] PRE_RST = 3'h0;
	// clock source selections
	typedef enum logic [1:0] {DTC_SRC_PRESCALE, DTC_SRC_EXT, DTC_SRC_LATCH, DTC_SRC_STOP} dtc_src_t;
	// capture edge selection
	typedef enum logic [1:0] {DTC_EDGE_NONE, DTC_EDGE_RISE, DTC_EDGE_FALL, DTC_EDGE_BOTH} dtc_edge_t;
endpackage

// ### rtl/dtc_top.sv
// dual up/down timer pair with shared capture/reload register
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - timers step at most once per two clocks
// - two timers plus one capture/reload register
// - count clock from prescaler or external pin
// - direction from software or direction pin
// - core toggle latch flips on over/underflow
// - latch can clock aux timer; drives pin
// - core over/underflow clocks compare unit, reloads
// - capture pin edge copies aux timer
// - optional clear of aux timer after capture
// - neighbour count/direction inputs also trigger capture
// - all timers and register are sixteen bits
module dtc_top (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// auxiliary timer configuration
	input wire logic aux_run,
	input wire dtc_pkg::dtc_src_t aux_src,
	input wire logic [dtc_pkg::PRE_W-1:0] aux_prescale,
	input wire logic aux_dir_down,
	input wire logic aux_dir_pin_en,
	input wire logic aux_clear_on_capture,
	// core timer configuration
	input wire logic core_run,
	input wire dtc_pkg::dtc_src_t core_src,
	input wire logic [dtc_pkg::PRE_W-1:0] core_prescale,
	input wire logic core_dir_down,
	input wire logic core_dir_pin_en,
	input wire logic core_reload_en,
	// capture configuration
	input wire dtc_pkg::dtc_edge_t capture_edge,
	input wire logic capture_on_neighbour_count,
	input wire logic capture_on_neighbour_dir,
	// external pins
	input wire logic aux_count_pin,
	input wire logic aux_direction_input_pin,
	input wire logic core_count_pin,
	input wire logic core_direction_input_pin,
	input wire logic capture_trigger_pin,
	input wire logic neighbour_count_input,
	input wire logic neighbour_direction_input,
	// state and events
	output logic [dtc_pkg::TMR_W-1:0] aux_timer,
	output logic [dtc_pkg::TMR_W-1:0] core_timer,
	output logic [dtc_pkg::TMR_W-1:0] capture_reload_reg,
	output logic toggle_latch_out_pin,
	output logic core_ovf_pulse_ff,
	output logic capture_pulse_ff
);
	logic [dtc_pkg::TMR_W-1:0] aux_ff, core_ff, capture_reload_reg_ff;
	logic latch_ff, phase_ff;
	logic [7:0] aux_pre_ff, core_pre_ff;
	logic aux_pin_ff, core_pin_ff, cap_pin_ff, nbc_ff, nbd_ff, latch_prev_ff;
	logic aux_tick, core_tick, aux_down, core_down, core_wrap;
	logic cap_rise, cap_fall, cap_hit;
	logic aux_pending_ff, core_pending_ff;

	// base step: a tick may only happen on every other clock
	always_ff @(posedge clock) begin
		if (!rstn) begin
			phase_ff <= 1'b0;
		end else begin
			phase_ff <= ~phase_ff;
		end
	end

	// prescalers run in base steps, divide by 2^n steps
	always_ff @(posedge clock) begin
		if (!rstn) begin
			aux_pre_ff <= 8'h00;
			core_pre_ff <= 8'h00;
		end else if (phase_ff) begin
			aux_pre_ff <= aux_pre_ff + 8'h01;
			core_pre_ff <= core_pre_ff + 8'h01;
		end
	end

	// previous input levels for edge detection
	always_ff @(posedge clock) begin
		if (!rstn) begin
			aux_pin_ff <= 1'b0;
			core_pin_ff <= 1'b0;
			cap_pin_ff <= 1'b0;
			nbc_ff <= 1'b0;
			nbd_ff <= 1'b0;
			latch_prev_ff <= 1'b0;
		end else begin
			aux_pin_ff <= aux_count_pin;
			core_pin_ff <= core_count_pin;
			cap_pin_ff <= capture_trigger_pin;
			nbc_ff <= neighbour_count_input;
			nbd_ff <= neighbour_direction_input;
			latch_prev_ff <= latch_ff;
		end
	end

	// external and latch events are held until the next base step,
	// so an edge on an off-phase clock is counted late rather than lost
	always_ff @(posedge clock) begin
		if (!rstn) begin
			aux_pending_ff <= 1'b0;
			core_pending_ff <= 1'b0;
		end else if (phase_ff) begin
			aux_pending_ff <= 1'b0;
			core_pending_ff <= 1'b0;
		end else begin
			aux_pending_ff <= aux_pending_ff | (aux_src == dtc_pkg::DTC_SRC_LATCH ?
				(latch_ff != latch_prev_ff) : (aux_count_pin & ~aux_pin_ff));
			core_pending_ff <= core_pending_ff | (core_count_pin & ~core_pin_ff);
		end
	end

	// count clock selection; ext edges taken only on step cycles
	always_comb begin
		aux_tick = 1'b0;
		core_tick = 1'b0;
		case (aux_src)
			dtc_pkg::DTC_SRC_PRESCALE: aux_tick = phase_ff &&
				((aux_pre_ff & ((8'h01 << aux_prescale) - 8'h01)) == 8'h00);
			dtc_pkg::DTC_SRC_EXT: aux_tick = phase_ff && (aux_pending_ff ||
				(aux_count_pin & ~aux_pin_ff));
			dtc_pkg::DTC_SRC_LATCH: aux_tick = phase_ff && (aux_pending_ff ||
				(latch_ff != latch_prev_ff));
			default: aux_tick = 1'b0;
		endcase
		case (core_src)
			dtc_pkg::DTC_SRC_PRESCALE: core_tick = phase_ff &&
				((core_pre_ff & ((8'h01 << core_prescale) - 8'h01)) == 8'h00);
			dtc_pkg::DTC_SRC_EXT: core_tick = phase_ff && (core_pending_ff ||
				(core_count_pin & ~core_pin_ff));
			default: core_tick = 1'b0;
		endcase
		aux_tick = aux_tick & aux_run;
		core_tick = core_tick & core_run;
	end

	// direction from software bit or pin level
	assign aux_down = aux_dir_pin_en ? aux_direction_input_pin : aux_dir_down;
	assign core_down = core_dir_pin_en ? core_direction_input_pin : core_dir_down;
	assign core_wrap = core_tick && (core_down ? core_ff == dtc_pkg::TMR_RST :
		core_ff == dtc_pkg::TMR_MAX);

	// core timer with optional reload on wrap
	always_ff @(posedge clock) begin
		if (!rstn) begin
			core_ff <= dtc_pkg::TMR_RST;
		end else if (core_wrap && core_reload_en) begin
			core_ff <= capture_reload_reg_ff;
		end else if (core_tick) begin
			core_ff <= core_down ? core_ff - 16'h0001 : core_ff + 16'h0001;
		end
	end

	// toggle latch and wrap pulse for the external compare unit
	always_ff @(posedge clock) begin
		if (!rstn) begin
			latch_ff <= 1'b0;
			core_ovf_pulse_ff <= 1'b0;
		end else begin
			latch_ff <= latch_ff ^ core_wrap;
			core_ovf_pulse_ff <= core_wrap;
		end
	end

	// capture triggers
	assign cap_rise = capture_trigger_pin & ~cap_pin_ff;
	assign cap_fall = ~capture_trigger_pin & cap_pin_ff;
	assign cap_hit = (capture_edge == dtc_pkg::DTC_EDGE_RISE && cap_rise) ||
		(capture_edge == dtc_pkg::DTC_EDGE_FALL && cap_fall) ||
		(capture_edge == dtc_pkg::DTC_EDGE_BOTH && (cap_rise || cap_fall)) ||
		(capture_on_neighbour_count && (neighbour_count_input != nbc_ff)) ||
		(capture_on_neighbour_dir && (neighbour_direction_input != nbd_ff));

	// capture/reload register
	always_ff @(posedge clock) begin
		if (!rstn) begin
			capture_reload_reg_ff <= dtc_pkg::TMR_RST;
			capture_pulse_ff <= 1'b0;
		end else begin
			capture_pulse_ff <= cap_hit;
			if (cap_hit) begin
				capture_reload_reg_ff <= aux_ff;
			end
		end
	end

	// auxiliary timer; clear after capture takes priority over a tick
	always_ff @(posedge clock) begin
		if (!rstn) begin
			aux_ff <= dtc_pkg::TMR_RST;
		end else if (cap_hit && aux_clear_on_capture) begin
			aux_ff <= dtc_pkg::TMR_RST;
		end else if (aux_tick) begin
			aux_ff <= aux_down ? aux_ff - 16'h0001 : aux_ff + 16'h0001;
		end
	end

	// outputs straight from flip-flops
	assign aux_timer = aux_ff;
	assign core_timer = core_ff;
	assign capture_reload_reg = capture_reload_reg_ff;
	assign toggle_latch_out_pin = latch_ff;

	// aux never moves on two consecutive clocks except by a clear after capture
	aux_step_rate_a: assert property (@(posedge clock) disable iff (!rstn)
		(aux_ff != $past(aux_ff) && !$past(cap_hit)) |=> (aux_ff == $past(aux_ff) || $past(cap_hit)))
		else $error("aux timer stepped twice in a row");
	core_step_rate_a: assert property (@(posedge clock) disable iff (!rstn)
		core_ff != $past(core_ff) |=> core_ff == $past(core_ff))
		else $error("core timer stepped twice in a row");
	latch_flip_wrap_a: assert property (@(posedge clock) disable iff (!rstn)
		core_wrap |=> latch_ff != $past(latch_ff))
		else $error("toggle latch missed a wrap");
	latch_hold_a: assert property (@(posedge clock) disable iff (!rstn)
		!core_wrap |=> latch_ff == $past(latch_ff))
		else $error("toggle latch changed without wrap");
	core_reload_a: assert property (@(posedge clock) disable iff (!rstn)
		(core_wrap && core_reload_en) |=> core_ff == $past(capture_reload_reg_ff))
		else $error("core timer not reloaded");
	cap_copy_a: assert property (@(posedge clock) disable iff (!rstn)
		cap_hit |=> capture_reload_reg == $past(aux_ff) && capture_pulse_ff)
		else $error("capture value wrong");
	cap_clear_a: assert property (@(posedge clock) disable iff (!rstn)
		(cap_hit && aux_clear_on_capture) |=> aux_ff == 16'h0000)
		else $error("aux timer not cleared after capture");
	ovf_pulse_a: assert property (@(posedge clock) disable iff (!rstn)
		core_wrap |=> core_ovf_pulse_ff ##1 !core_ovf_pulse_ff || $past(core_wrap))
		else $error("overflow pulse wrong");
	aux_up_a: assert property (@(posedge clock) disable iff (!rstn)
		(aux_tick && !aux_down && !cap_hit) |=> aux_ff == $past(aux_ff) + 16'h0001)
		else $error("aux timer did not count up");
	latch_step_a: assert property (@(posedge clock) disable iff (!rstn)
		(aux_run && aux_src == dtc_pkg::DTC_SRC_LATCH && latch_ff != latch_prev_ff
		&& !aux_clear_on_capture) |-> ##[0:2] aux_tick)
		else $error("latch change did not step aux timer");
endmodule
`default_nettype wire

// ### verif/dtc_pins_model.sv
// pin-level model of the parties beyond the timer pair
`timescale 1ns/1ps
`default_nettype none
module dtc_pins_model (
	// clock
	input wire logic clock,
	// pins toward the timers
	output logic aux_count_pin,
	output logic core_direction_input_pin,
	output logic capture_trigger_pin,
	output logic neighbour_count_input,
	output logic neighbour_direction_input
);
	initial begin
		aux_count_pin = 1'b0;
		core_direction_input_pin = 1'b0;
		capture_trigger_pin = 1'b0;
		neighbour_count_input = 1'b0;
		neighbour_direction_input = 1'b0;
	end
	// rising edges four clocks apart, well above the two-clock spacing
	task automatic count_edges(input int n);
		repeat (n) begin
			@(posedge clock) aux_count_pin <= 1'b1;
			repeat (2) @(posedge clock);
			aux_count_pin <= 1'b0;
			@(posedge clock);
		end
	endtask
	// one level change per call, launched just after an edge
	task automatic flip(input int pin);
		@(posedge clock);
		case (pin)
			0: capture_trigger_pin <= !capture_trigger_pin;
			1: neighbour_count_input <= !neighbour_count_input;
			2: neighbour_direction_input <= !neighbour_direction_input;
			default: core_direction_input_pin <= !core_direction_input_pin;
		endcase
	endtask
endmodule
`default_nettype wire

// ### verif/dtc_top_tb.sv
// self-checking bench for the dual timer pair
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module dtc_top_tb;
	logic clock = 1'b0, rstn = 1'b0, aux_run = 1'b0, aux_dir_down = 1'b0, aux_dir_pin_en = 1'b0;
	logic aux_clear_on_capture = 1'b0, aux_direction_input_pin = 1'b0, core_count_pin = 1'b0;
	logic core_run = 1'b0, core_dir_down = 1'b0, core_dir_pin_en = 1'b0, core_reload_en = 1'b0;
	logic capture_on_neighbour_count = 1'b0, capture_on_neighbour_dir = 1'b0;
	logic [2:0] aux_prescale = 3'h0, core_prescale = 3'h0;
	dtc_pkg::dtc_src_t aux_src = dtc_pkg::DTC_SRC_STOP, core_src = dtc_pkg::DTC_SRC_STOP;
	dtc_pkg::dtc_edge_t capture_edge = dtc_pkg::DTC_EDGE_NONE;
	logic aux_count_pin, core_direction_input_pin, capture_trigger_pin;
	logic neighbour_count_input, neighbour_direction_input;
	logic toggle_latch_out_pin, core_ovf_pulse_ff, capture_pulse_ff;
	logic [15:0] aux_timer, core_timer, capture_reload_reg, v;
	int num_errors = 0, checked = 0, ncap = 0, nwrap = 0, k, p;
	dtc_top dtc_top_inst (.clock, .rstn, .aux_run, .aux_src, .aux_prescale, .aux_dir_down,
		.aux_dir_pin_en, .aux_clear_on_capture, .core_run, .core_src, .core_prescale,
		.core_dir_down, .core_dir_pin_en, .core_reload_en, .capture_edge,
		.capture_on_neighbour_count, .capture_on_neighbour_dir, .aux_count_pin,
		.aux_direction_input_pin, .core_count_pin, .core_direction_input_pin,
		.capture_trigger_pin, .neighbour_count_input, .neighbour_direction_input, .aux_timer,
		.core_timer, .capture_reload_reg, .toggle_latch_out_pin, .core_ovf_pulse_ff,
		.capture_pulse_ff);
	dtc_pins_model dtc_pins_model_inst (.clock, .aux_count_pin, .core_direction_input_pin,
		.capture_trigger_pin, .neighbour_count_input, .neighbour_direction_input);
	always #50 clock = !clock;
	// pulses stand one cycle, so they are tallied at every edge
	always @(posedge clock) begin
		ncap <= ncap + (capture_pulse_ff === 1'b1);
		nwrap <= nwrap + (core_ovf_pulse_ff === 1'b1);
	end
	function automatic int hits(input int e, input logic rise);
		return (e == 3) || (e == 1 && rise) || (e == 2 && !rise);
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic test_done;
		if (num_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// cut a hang short
	initial begin
		cyc(20000);
		num_errors++;
		test_done;
	end
	initial begin
		void'($urandom(66736));
		cyc(2);
		rstn <= 1'b1;
		cyc(1);
		`CHK(aux_timer, 16'h0000)
		`CHK(core_timer, 16'h0000)
		`CHK(capture_reload_reg, 16'h0000)
		// prescaled counting; settle 40 clocks since the divisor changes on the fly
		aux_src <= dtc_pkg::DTC_SRC_PRESCALE;
		repeat (4) begin
			p = $urandom_range(3);
			k = $urandom_range(1);
			aux_prescale <= p[2:0];
			aux_dir_pin_en <= k[0];
			aux_direction_input_pin <= 1'($urandom_range(1));
			aux_dir_down <= 1'($urandom_range(1));
			aux_run <= 1'b1;
			cyc(40);
			v = aux_timer;
			cyc(16 << p);
			`CHK(16'(aux_timer - v), (k[0] ? aux_direction_input_pin : aux_dir_down) ? 16'hfff8 : 16'h0008)
		end
		aux_src <= dtc_pkg::DTC_SRC_EXT;
		aux_dir_pin_en <= 1'b0;
		aux_dir_down <= 1'b0;
		cyc(4);
		v = aux_timer;
		k = $urandom_range(8, 1);
		dtc_pins_model_inst.count_edges(k);
		cyc(4);
		`CHK(16'(aux_timer - v), k[15:0])
		aux_run <= 1'b0;
		cyc(4);
		v = aux_timer;
		// every edge selection against both pin directions
		for (int e = 0; e < 4; e++) begin
			capture_edge <= dtc_pkg::dtc_edge_t'(e);
			repeat (2) begin
				k = ncap + hits(e, !capture_trigger_pin);
				dtc_pins_model_inst.flip(0);
				cyc(4);
				`CHK(ncap, k)
			end
		end
		`CHK(capture_reload_reg, v)
		aux_clear_on_capture <= 1'b1;
		dtc_pins_model_inst.flip(0);
		cyc(4);
		`CHK(aux_timer, 16'h0000)
		aux_clear_on_capture <= 1'b0;
		// direction pin flipped after each wrap, so every tick wraps
		aux_src <= dtc_pkg::DTC_SRC_LATCH;
		aux_run <= 1'b1;
		core_src <= dtc_pkg::DTC_SRC_PRESCALE;
		core_prescale <= 3'h3;
		core_dir_pin_en <= 1'b1;
		dtc_pins_model_inst.flip(3);
		core_run <= 1'b1;
		for (int w = 1; w <= 5; w++) begin
			core_reload_en <= (w == 5);
			for (k = 0; k < 100 && nwrap < w; k++) cyc(1);
			cyc(3);
			`CHK(toggle_latch_out_pin, w[0])
			`CHK(aux_timer, w[15:0])
			`CHK(core_timer, w == 5 ? v : (w[0] ? 16'hffff : 16'h0000))
			dtc_pins_model_inst.flip(3);
		end
		`CHK(nwrap, 5)
		core_run <= 1'b0;
		aux_run <= 1'b0;
		capture_edge <= dtc_pkg::DTC_EDGE_NONE;
		capture_on_neighbour_count <= 1'b1;
		capture_on_neighbour_dir <= 1'b1;
		for (int n = 1; n <= 2; n++) begin
			k = ncap + 1;
			dtc_pins_model_inst.flip(n);
			cyc(4);
			`CHK(ncap, k)
		end
		`CHK(capture_reload_reg, 16'h0005)
		// core counted from its own pin; edges three clocks apart hit both phases
		core_src <= dtc_pkg::DTC_SRC_EXT;
		core_dir_pin_en <= 1'b0;
		core_reload_en <= 1'b0;
		k = $urandom_range(1);
		core_dir_down <= k[0];
		core_run <= 1'b1;
		cyc(2);
		v = core_timer;
		p = $urandom_range(6, 1);
		repeat (p) begin
			core_count_pin <= 1'b1;
			cyc(2);
			core_count_pin <= 1'b0;
			cyc(1);
		end
		cyc(4);
		`CHK(16'(core_timer - v), k[0] ? 16'(-p) : p[15:0])
		// a stopped source ignores its pin
		core_src <= dtc_pkg::DTC_SRC_STOP;
		v = core_timer;
		repeat (2) begin
			core_count_pin <= 1'b1;
			cyc(2);
			core_count_pin <= 1'b0;
			cyc(1);
		end
		`CHK(core_timer, v)
		// reset in mid-run clears both timers, the capture/reload register and the latch
		rstn <= 1'b0;
		cyc(2);
		rstn <= 1'b1;
		cyc(1);
		`CHK(aux_timer, 16'h0000)
		`CHK(core_timer, 16'h0000)
		`CHK(capture_reload_reg, 16'h0000)
		`CHK(toggle_latch_out_pin, 1'b0)
		test_done;
	end
endmodule
`default_nettype wire
